// ==== hdl/dacf_status_flags.sv ====
`timescale 1ns/1ps
`include "dacf_cfg.svh"
// Overview of operation
// - Saturation of accumulator A sets a sticky latch until cleared.
// - Accumulator B saturation sets a sticky latch, held until cleared.
// - A status write with the combined clip bit set loads both clip latches with written values.
// - Writing zero to the combined clip bit clears both clip latches.
module dacf_status_flags (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  output logic [1:0]       avsResponse,
  // Core arithmetic events (same clock)
  input  wire logic        accAOverflow,
  input  wire logic        accBOverflow,
  input  wire logic        accASaturate,
  input  wire logic        accBSaturate,
  // Interrupt
  output logic             irq
);
  // Bus handshake state
  dacf_pkg::dacf_bus_e  state_q;
  dacf_pkg::dacf_bus_e  state_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic [1:0]           resp_q;
  logic [1:0]           resp_d;
  // Flag state
  logic [3:0]           irqStat;
  logic [3:0]           irqMask_q;
  logic [3:0]           irqMask_d;
  logic                 clipA;
  logic                 clipB;
  logic                 ovfA_q;
  logic                 ovfB_q;
  logic                 ovfA_d;
  logic                 ovfB_d;
  dacf_pkg::dacf_word_t statusWord;

  // Transfer decode
  wire busy      = avsRead | avsWrite;
  wire inIdle    = state_q == dacf_pkg::BusIdle;
  wire inAck     = state_q == dacf_pkg::BusAck;
  wire req       = busy & inIdle;
  // Writes land on the completing edge, when the master sees no wait
  wire wrTake    = avsWrite & inAck;
  wire hitStatus = avsAddress == `DACF_ADDR_STATUS;
  wire hitIStat  = avsAddress == `DACF_ADDR_IRQ_STAT;
  wire hitIMask  = avsAddress == `DACF_ADDR_IRQ_MASK;
  wire mapped    = hitStatus | hitIStat | hitIMask;
  wire hiLane    = avsByteEnable[1];
  wire loLane    = avsByteEnable[0];
  wire wrStatHi  = wrTake & hitStatus & hiLane;
  wire wrIStat   = wrTake & hitIStat & loLane;
  wire wrIMask   = wrTake & hitIMask & loLane;

  // Combined clip written as zero clears both latches
  wire clipAnyClr = wrStatHi & ~avsWriteData[`DACF_BIT_CLIP_ANY];
  wire loadClip   = wrStatHi;
  wire loadValA   = avsWriteData[`DACF_BIT_CLIP_A] & ~clipAnyClr;
  wire loadValB   = avsWriteData[`DACF_BIT_CLIP_B] & ~clipAnyClr;

  // Overflow flags latch core events until written; a software write may load them
  wire ovfWrA   = avsWriteData[`DACF_BIT_OVF_A];
  wire ovfWrB   = avsWriteData[`DACF_BIT_OVF_B];
  wire ovfKeepA = wrStatHi ? ovfWrA : ovfA_q;
  wire ovfKeepB = wrStatHi ? ovfWrB : ovfB_q;

  // Core overflow overrides a software clear in the same cycle
  assign ovfA_d = accAOverflow | ovfKeepA;
  assign ovfB_d = accBOverflow | ovfKeepB;

  dacf_sticky_bit u_clipA (
    .ref_clk (ref_clk),
    .rst     (rst),
    .setEvt  (accASaturate),
    .loadEn  (loadClip),
    .loadVal (loadValA),
    .flag    (clipA)
  );

  dacf_sticky_bit u_clipB (
    .ref_clk (ref_clk),
    .rst     (rst),
    .setEvt  (accBSaturate),
    .loadEn  (loadClip),
    .loadVal (loadValB),
    .flag    (clipB)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovfA_q <= 1'b0;
    end else begin
      ovfA_q <= ovfA_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovfB_q <= 1'b0;
    end else begin
      ovfB_q <= ovfB_d;
    end
  end

  // Status word: unused bits read as zero
  always_comb begin
    statusWord = `DACF_RST_STATUS;
    statusWord[`DACF_BIT_OVF_A]    = ovfA_q;
    statusWord[`DACF_BIT_OVF_B]    = ovfB_q;
    statusWord[`DACF_BIT_CLIP_A]   = clipA;
    statusWord[`DACF_BIT_CLIP_B]   = clipB;
    statusWord[`DACF_BIT_OVF_ANY]  = ovfA_q | ovfB_q;
    statusWord[`DACF_BIT_CLIP_ANY] = clipA | clipB;
  end

  // Interrupt sources, taken as levels: each high cycle sets its bit
  wire       evtClipA = accASaturate;
  wire       evtClipB = accBSaturate;
  wire       evtOvfA  = accAOverflow;
  wire       evtOvfB  = accBOverflow;
  wire [3:0] evt      = {evtOvfB, evtOvfA, evtClipB, evtClipA};

  // One sticky bit per source; write-one clears, a new event wins
  for (genvar i = 0; i < 4; i++) begin : g_irq
    wire clrBit = wrIStat & avsWriteData[i];

    dacf_sticky_bit u_irqBit (
      .ref_clk (ref_clk),
      .rst     (rst),
      .setEvt  (evt[i]),
      .loadEn  (clrBit),
      .loadVal (1'b0),
      .flag    (irqStat[i])
    );
  end

  assign irqMask_d = wrIMask ? avsWriteData[3:0] : irqMask_q;
  assign irq       = |(irqStat & irqMask_q);

  // Read data chosen at the taking edge and held through the ack cycle
  wire [31:0] rdStatus = {16'h0000, statusWord};
  wire [31:0] rdIStat  = {28'h0000000, irqStat};
  wire [31:0] rdIMask  = {28'h0000000, irqMask_q};
  wire [31:0] rdSel    = !avsRead  ? 32'h0000_0000 :
                         hitStatus ? rdStatus :
                         hitIStat  ? rdIStat :
                         hitIMask  ? rdIMask : 32'h0000_0000;
  // Unmapped words answer with a slave error, writes there are dropped
  wire [1:0]  respSel  = mapped ? 2'h0 : 2'h2;

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    resp_d  = resp_q;
    case (state_q)
      dacf_pkg::BusIdle: begin
        if (req) begin
          state_d = dacf_pkg::BusAck;
          resp_d  = respSel;
          rdata_d = rdSel;
        end
      end
      dacf_pkg::BusAck: begin
        state_d = dacf_pkg::BusIdle;
      end
      default: begin
        state_d = dacf_pkg::BusIdle;
      end
    endcase
  end

  // Exactly one wait cycle per transfer
  assign avsWaitRequest = busy & ~inAck;
  assign avsReadData    = rdata_q;
  assign avsResponse    = resp_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= dacf_pkg::BusIdle;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resp_q <= 2'h0;
    end else begin
      resp_q <= resp_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqMask_q <= `DACF_RST_IRQ;
    end else begin
      irqMask_q <= irqMask_d;
    end
  end
endmodule // dacf_status_flags

// ==== hdl/dacf_cfg.svh ====
`ifndef DACF_CFG_SVH
`define DACF_CFG_SVH

// Register word addresses (byte address = index * 4)
`define DACF_ADDR_STATUS     4'h0
`define DACF_ADDR_IRQ_STAT   4'h1
`define DACF_ADDR_IRQ_MASK   4'h2

// Field positions in cpu_status_flags
`define DACF_BIT_OVF_A       15
`define DACF_BIT_OVF_B       14
`define DACF_BIT_CLIP_A      13
`define DACF_BIT_CLIP_B      12
`define DACF_BIT_OVF_ANY     11
`define DACF_BIT_CLIP_ANY    10

// Interrupt status layout
`define DACF_IRQ_CLIP_A      0
`define DACF_IRQ_CLIP_B      1
`define DACF_IRQ_OVF_A       2
`define DACF_IRQ_OVF_B       3

`define DACF_RST_STATUS      16'h0000
`define DACF_RST_IRQ         4'h0

`endif

// ==== hdl/dacf_pkg.sv ====
package dacf_pkg;
  typedef enum logic [1:0] {BusIdle, BusAck} dacf_bus_e;
  typedef logic [15:0] dacf_word_t;
endpackage

// ==== hdl/dacf_sticky_bit.sv ====
`timescale 1ns/1ps
`include "dacf_cfg.svh"
// One sticky flag: hardware set wins over any software load.
module dacf_sticky_bit (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control
  input  wire logic setEvt,
  input  wire logic loadEn,
  input  wire logic loadVal,
  // State
  output logic      flag
);
  logic flag_q;
  logic flag_d;

  assign flag_d = setEvt ? 1'b1 : (loadEn ? loadVal : flag_q);
  assign flag   = flag_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // dacf_sticky_bit

// ==== tb/dacf_chk.sv ====
`timescale 1ns/1ps
module dacf_chk (
  // Bus
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  // Core events
  input wire logic        accASaturate,
  input wire logic        accBSaturate
);
  logic [2:0] satHist_q;
  wire rdAck = avsRead && !avsWaitRequest && avsAddress == 4'h0;
  wire wrAck = avsWrite && !avsWaitRequest && avsAddress == 4'h0
               && avsByteEnable[1];
  always_ff @(posedge ref_clk) begin
    satHist_q <= {satHist_q[1:0], accASaturate | accBSaturate};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_clip_a_set:
  assert property ($past(accASaturate, 2) && !$past(rst, 2) && rdAck
    |-> avsReadData[13]) else $error("clip A not latched");
  chk_clip_b_set:
  assert property ($past(accBSaturate, 2) && !$past(rst, 2) && rdAck
    |-> avsReadData[12]) else $error("clip B not latched");
  chk_clip_load:
  assert property (rdAck && $past(wrAck, 3) && $past(avsWriteData[10], 3)
    && satHist_q == 3'h0
    |-> avsReadData[13:12] == $past(avsWriteData[13:12], 3))
    else $error("clip load lost");
  chk_clip_clear:
  assert property (rdAck && $past(wrAck, 3) && !$past(avsWriteData[10], 3)
    && satHist_q == 3'h0 |-> avsReadData[13:12] == 2'h0)
    else $error("clip clear lost");
  chk_summary_or:
  assert property (rdAck |-> avsReadData[11] == |avsReadData[15:14]
    && avsReadData[10] == |avsReadData[13:12]) else $error("summary wrong");
endmodule // dacf_chk

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 0, rst = 1, avsRead = 0, avsWrite = 0, irq;
  logic        accAOverflow = 0, accBOverflow = 0, avsWaitRequest;
  logic        accASaturate = 0, accBSaturate = 0;
  logic [3:0]  avsAddress = 4'h0, avsByteEnable = 4'hf;
  logic [31:0] avsWriteData = 0, avsReadData;
  logic [1:0]  avsResponse;
  logic [33:0] expQ[$];
  logic [15:0] wd;
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  dacf_status_flags uut (.ref_clk, .rst, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest,
    .avsResponse, .accAOverflow, .accBOverflow, .accASaturate,
    .accBSaturate, .irq);
  always #2.5 ref_clk = ~ref_clk;
  task check(input string nm, input logic [33:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Read expectation in d; unmapped places answer with response 2
  task xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    avsWrite <= w; avsRead <= !w; avsAddress <= a; avsWriteData <= d;
    if (!w) expQ.push_back({(a > 4'h2) ? 2'h2 : 2'h0, 16'h0, d});
    @(posedge ref_clk);
    while (avsWaitRequest !== 1'b0) @(posedge ref_clk);
    avsWrite <= 0; avsRead <= 0; @(posedge ref_clk);
  endtask
  task pulse(input bit b);
    if (b) accBSaturate <= 1; else accASaturate <= 1;
    @(posedge ref_clk); accASaturate <= 0; accBSaturate <= 0;
  endtask
  always @(posedge ref_clk) begin
    if (avsRead && !avsWaitRequest)
      check("read", {avsResponse, avsReadData}, expQ.pop_front());
    if (++cyc == 3000) begin
      n_mismatch++; print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h2e6f));
    repeat (8) @(posedge ref_clk); rst <= 0; @(posedge ref_clk);
    xfer(0, 0, 16'h0000);
    pulse(0); xfer(0, 0, 16'h2400); xfer(0, 0, 16'h2400);
    pulse(1); xfer(0, 0, 16'h3400);
    xfer(1, 0, 16'h0400); xfer(0, 0, 16'h0000);
    xfer(1, 0, 16'h3400); xfer(0, 0, 16'h3400);
    xfer(1, 0, 16'h3000); xfer(0, 0, 16'h0000);
    accBOverflow <= 1; @(posedge ref_clk);
    xfer(0, 0, 16'h4800); accBOverflow <= 0;
    xfer(1, 0, 16'h0400); xfer(0, 0, 16'h0000);
    accAOverflow <= 1; @(posedge ref_clk);
    xfer(0, 0, 16'h8800); accAOverflow <= 0;
    xfer(1, 0, 16'h0400); xfer(0, 0, 16'h0000);
    $display("flag tests done");
    check("irq", irq, 0);
    xfer(1, 2, 16'h000f); check("irq", irq, 1);
    xfer(1, 1, 16'h000f); check("irq", irq, 0);
    xfer(0, 1, 16'h0000); xfer(0, 5, 16'h0000);
    $display("irq tests done");
    repeat (4) begin
      wd = 16'($urandom) & 16'h3400; xfer(1, 0, wd);
      xfer(0, 0, wd[10] ? {2'h0, wd[13:12], 1'b0, |wd[13:12], 10'h0}
        : 16'h0);
    end
    $display("random tests done");
    print_verdict();
  end
endmodule // tb
bind dacf_status_flags dacf_chk u_chk (.ref_clk, .rst, .avsAddress,
  .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData,
  .avsWaitRequest, .accASaturate, .accBSaturate);
